// >>> logic/mcpls_pkg.sv
`default_nettype none
package mcpls_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned PHY_RST_NS = 10000; // Length of a PHY reset pulse
    localparam int unsigned PHY_RST_CYC = (PHY_RST_NS * CLK_MHZ + 999) / 1000;

    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [7:0] IDX_MC_CONFIG = 8'h40;
    localparam logic [7:0] IDX_INIT_LOW = 8'h43;
    localparam logic [7:0] IDX_LOOP_SETUP = 8'h44;
    localparam logic [7:0] IDX_STATUS = 8'h7E;

    // ---------------------------------------------------------------
    // Field positions, codes and reset values
    // ---------------------------------------------------------------
    localparam int unsigned BIT_LLP_EN = 2;
    localparam int unsigned BIT_FIBER_TXD = 1;
    localparam int unsigned BIT_PHY_RST = 0;
    localparam int unsigned ST_LOOP_BUSY = 0;
    localparam int unsigned ST_PHY_RST = 1;
    localparam int unsigned ST_COPPER_TXD = 2;
    localparam int unsigned ST_FIBER_UP = 3;
    localparam int unsigned ST_CENTER_UP = 4;
    localparam int unsigned ST_CENTER_MODE = 5;
    localparam int unsigned ST_REMAIN_LSB = 8;
    localparam logic [7:0] MC_CONFIG_RST = 8'h00;
    localparam logic [7:0] LOOP_SETUP_RST = 8'h07;
    localparam logic [7:0] LOOP_CLEAR_CODE = 8'h00;
    localparam logic [7:0] LOOP_MAX_CODE = 8'h64;

    // ---------------------------------------------------------------
    // Carriers and states
    // ---------------------------------------------------------------
    typedef struct packed {
        logic fiber_up;
        logic center_copper_up;
    } mcpls_link_s;

    typedef struct packed {
        logic copper_tx_disable;
        logic copper_led_off;
        logic fiber_tx_oe;
    } mcpls_ctl_s;

    typedef struct packed {
        logic frame_ctr_clear;
        logic loop_result_clear;
    } mcpls_clr_s;

    typedef enum logic [1:0] {
        LOOP_IDLE = 2'b01,
        LOOP_SEND = 2'b10
    } mcpls_loop_e;

endpackage
`default_nettype wire

// >>> logic/mcpls_loop_seq.sv
`timescale 1ns/100ps
`default_nettype none
module mcpls_loop_seq
    import mcpls_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, active low
    input wire logic start, // Load a packet count and begin
    input wire logic [CNT_W-1:0] count, // Packets to send
    output logic pkt_req, // Request one loopback packet
    input wire logic pkt_ack, // Packet has been sent
    output logic busy, // Sequence in progress
    output logic [CNT_W-1:0] remaining // Packets still to send
);

    mcpls_loop_e state_r;
    mcpls_loop_e state_nxt;
    logic [CNT_W-1:0] remain_r;
    logic [CNT_W-1:0] remain_nxt;
    wire last_ack = pkt_ack && (state_r == LOOP_SEND) && (remain_r == CNT_W'(1));

    // ---------------------------------------------------------------
    // Next state: a fresh start restarts the count
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        remain_nxt = remain_r;
        case (state_r)
            LOOP_IDLE: begin
                state_nxt = LOOP_IDLE;
            end
            LOOP_SEND: begin
                if (pkt_ack) begin
                    remain_nxt = remain_r - CNT_W'(1);
                end
                if (last_ack) begin
                    state_nxt = LOOP_IDLE;
                end
            end
            default: begin
                state_nxt = LOOP_IDLE;
                remain_nxt = '0;
            end
        endcase
        if (start && (count != '0)) begin
            state_nxt = LOOP_SEND;
            remain_nxt = count;
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= LOOP_IDLE;
            remain_r <= '0;
        end else begin
            state_r <= state_nxt;
            remain_r <= remain_nxt;
        end
    end

    assign pkt_req = (state_r == LOOP_SEND);
    assign busy = (state_r == LOOP_SEND);
    assign remaining = remain_r;

endmodule
`default_nettype wire

// >>> logic/mcpls_rst_pulse.sv
`timescale 1ns/100ps
`default_nettype none
module mcpls_rst_pulse
    import mcpls_pkg::*;
#(
    parameter int unsigned CYCLES = PHY_RST_CYC
) (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, active low
    input wire logic trigger, // Start a timed pulse
    input wire logic hold, // Keep the pulse asserted
    output logic pulse // Registered reset out, active high
);

    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_r;
    logic pulse_r;
    wire [CW-1:0] cnt_nxt = trigger ? CW'(CYCLES) : ((cnt_r != '0) ? cnt_r - CW'(1) : cnt_r);

    initial begin
        if (CYCLES < 1) begin
            $error("pulse length must be at least one cycle");
        end
    end

    // Counter and output flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            pulse_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            pulse_r <= hold || (cnt_nxt != '0);
        end
    end

    assign pulse = pulse_r;

endmodule
`default_nettype wire

// >>> logic/mcpls_top.sv
// Notes on behaviour
// RULE1: In terminal mode with link-loss propagation on, a fiber or center copper link down disables copper TX and its LEDs.
// RULE2: In center mode the link-loss propagation bit has no effect at all.
// RULE3: The fiber transmit disable bit set to one tri-states the fiber transmit output, zero restores it.
// RULE4: Writing one to the PHY reset bit resets both PHYs, and the bit then clears by itself.
// RULE5: A PHY reset from that bit leaves every maintenance register unchanged.
// RULE6: The PHY reset bit powers up as one in center mode until register 0x40 is written, and as zero otherwise.
// RULE7: Writing zero to the loopback setup register clears the valid transmit and receive frame counters.
// RULE8: In center mode that zero write also clears the loopback result counters.
// RULE9: The counter clearing code is honoured in both center and terminal mode.
// RULE10: In center mode a setup value N from 1 to 100 sends N loopback packets.
// RULE11: The loopback setup register resets to seven.
// RULE12: Software must not write setup values from 0x65 to 0xFF, their effect is undefined.
// RULE13: Only the center mode acts on the packet count codes.
`timescale 1ns/100ps
`default_nettype none
module mcpls_top
    import mcpls_pkg::*;
#(
    parameter int unsigned MAX_PACKETS = 100,
    parameter int unsigned RST_CYCLES = PHY_RST_CYC
) (
    input wire logic pclk, // Core clock, 25 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic media_converter_center, // 1 = center mode, 0 = terminal
    input wire logic link_loss_strap, // Strap for propagation enable
    input wire mcpls_link_s link_in, // Link status of fiber and center copper
    output mcpls_ctl_s ctl_out, // Copper and fiber transmit controls
    output logic phy_reset, // Reset to both PHYs, active high
    output mcpls_clr_s clr_out, // One-cycle counter clear pulses
    output logic loop_pkt_req, // Request one loopback packet
    input wire logic loop_pkt_ack // Loopback packet sent
);

    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    initial begin
        if (MAX_PACKETS < 1 || MAX_PACKETS > 255) begin
            $error("packet count must fit the 8-bit setup register");
        end
        if (RST_CYCLES < 1) begin
            $error("PHY reset must last at least one cycle");
        end
    end

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        reg_hit = (addr == {2'b00, idx, 2'b00});
    endfunction

    wire hit_cfg = reg_hit(paddr, IDX_MC_CONFIG);
    wire hit_init = reg_hit(paddr, IDX_INIT_LOW);
    wire hit_loop = reg_hit(paddr, IDX_LOOP_SETUP);
    wire hit_stat = reg_hit(paddr, IDX_STATUS);
    wire hit_any = hit_cfg || hit_init || hit_loop || hit_stat;
    wire setup_ph = psel && !penable;
    wire access_ph = psel && penable;
    wire wr_ok = access_ph && pwrite && hit_any;
    wire wr_cfg = wr_ok && hit_cfg;
    wire wr_init = wr_ok && hit_init;
    wire wr_loop = wr_ok && hit_loop;
    wire [7:0] wbyte = pwdata[7:0];

    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    logic [7:0] mc_config_r;
    logic [7:0] loop_setup_r;
    logic link_loss_propagate_enable_r;
    logic fiber_transmit_disable_r;
    logic phy_reset_bit_r;
    logic phy_reset_bit_nxt;
    logic strap_taken_r;
    logic hold_power_up_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    mcpls_ctl_s ctl_r;
    mcpls_ctl_s ctl_nxt;
    mcpls_clr_s clr_r;
    mcpls_clr_s clr_nxt;

    // Sequencer and reset pulse status
    logic loop_busy;
    logic [7:0] loop_remaining;
    logic phy_reset_pulse;

    // ---------------------------------------------------------------
    // Loopback setup decode
    // ---------------------------------------------------------------
    localparam logic [7:0] MAX_CODE = 8'(MAX_PACKETS);

    wire loop_clear = wr_loop && (wbyte == LOOP_CLEAR_CODE); // RULE9
    wire loop_count_code = (wbyte != LOOP_CLEAR_CODE) && (wbyte <= MAX_CODE);
    // Values above the limit are stored but start nothing
    wire loop_start = wr_loop && loop_count_code && media_converter_center; // RULE10 RULE13

    // Frame counters clear in both modes, result counters in center only
    always_comb begin
        clr_nxt.frame_ctr_clear = loop_clear; // RULE7
        clr_nxt.loop_result_clear = loop_clear && media_converter_center; // RULE8
    end

    // ---------------------------------------------------------------
    // PHY reset bit
    // ---------------------------------------------------------------
    // Write of one sets it for one cycle only, writing 0x40 drops the
    // power-up value; a one written in the same cycle still wins
    always_comb begin
        phy_reset_bit_nxt = phy_reset_bit_r;
        if (phy_reset_bit_r && !strap_taken_r) begin
            phy_reset_bit_nxt = phy_reset_bit_r;
        end else if (wr_cfg) begin
            phy_reset_bit_nxt = 1'b0; // RULE6
        end else if (phy_reset_bit_r && strap_taken_r && !hold_power_up_r) begin
            phy_reset_bit_nxt = 1'b0; // RULE4
        end
        if (wr_init && wbyte[BIT_PHY_RST]) begin
            phy_reset_bit_nxt = 1'b1; // RULE4
        end
        if (!strap_taken_r) begin
            phy_reset_bit_nxt = media_converter_center; // RULE6
        end
    end

    // Power-up reset is held until the config register is written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_power_up_r <= 1'b0;
        end else if (!strap_taken_r) begin
            hold_power_up_r <= media_converter_center; // RULE6
        end else if (wr_cfg) begin
            hold_power_up_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Control registers, straps caught at the first edge after release
    // ---------------------------------------------------------------
    // The PHY reset touches none of these, they follow only presetn
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_taken_r <= 1'b0;
            link_loss_propagate_enable_r <= 1'b0;
            fiber_transmit_disable_r <= 1'b0;
            phy_reset_bit_r <= 1'b0;
        end else begin
            strap_taken_r <= 1'b1;
            phy_reset_bit_r <= phy_reset_bit_nxt;
            if (!strap_taken_r) begin
                link_loss_propagate_enable_r <= link_loss_strap;
            end else if (wr_init) begin
                link_loss_propagate_enable_r <= wbyte[BIT_LLP_EN];
                fiber_transmit_disable_r <= wbyte[BIT_FIBER_TXD];
            end
        end
    end

    // Config and loopback setup registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_config_r <= MC_CONFIG_RST;
            loop_setup_r <= LOOP_SETUP_RST; // RULE11
        end else begin
            if (wr_cfg) begin
                mc_config_r <= wbyte;
            end
            if (wr_loop) begin
                loop_setup_r <= wbyte;
            end
        end
    end

    // ---------------------------------------------------------------
    // Link-loss propagation and fiber transmit
    // ---------------------------------------------------------------
    wire link_lost = !link_in.fiber_up || !link_in.center_copper_up;
    // Propagation acts only in terminal mode
    wire propagate = link_loss_propagate_enable_r && !media_converter_center; // RULE2

    always_comb begin
        ctl_nxt.copper_tx_disable = propagate && link_lost; // RULE1
        ctl_nxt.copper_led_off = propagate && link_lost; // RULE1
        ctl_nxt.fiber_tx_oe = !fiber_transmit_disable_r; // RULE3
    end

    // Output flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= '{copper_tx_disable: 1'b0, copper_led_off: 1'b0, fiber_tx_oe: 1'b1};
            clr_r <= '0;
        end else begin
            ctl_r <= ctl_nxt;
            clr_r <= clr_nxt;
        end
    end

    // ---------------------------------------------------------------
    // PHY reset pulse
    // ---------------------------------------------------------------
    mcpls_rst_pulse #(
        .CYCLES(RST_CYCLES)
    ) u_rst_pulse (
        .pclk(pclk),
        .presetn(presetn),
        .trigger(wr_init && wbyte[BIT_PHY_RST]), // RULE4 RULE5
        .hold(hold_power_up_r),
        .pulse(phy_reset_pulse)
    );

    // ---------------------------------------------------------------
    // Loopback packet sequencer
    // ---------------------------------------------------------------
    mcpls_loop_seq #(
        .CNT_W(8)
    ) u_loop_seq (
        .pclk(pclk),
        .presetn(presetn),
        .start(loop_start), // RULE10
        .count(wbyte),
        .pkt_req(loop_pkt_req),
        .pkt_ack(loop_pkt_ack),
        .busy(loop_busy),
        .remaining(loop_remaining)
    );

    // ---------------------------------------------------------------
    // Read data, captured in the setup phase
    // ---------------------------------------------------------------
    wire [31:0] init_word = {29'h0000000, link_loss_propagate_enable_r, fiber_transmit_disable_r, phy_reset_bit_r};
    wire [31:0] stat_word = {16'h0000, loop_remaining, 2'b00, media_converter_center,
        link_in.center_copper_up, link_in.fiber_up, ctl_r.copper_tx_disable, phy_reset_pulse, loop_busy};

    always_comb begin
        prdata_nxt = 32'h00000000;
        if (hit_cfg) begin
            prdata_nxt = {24'h000000, mc_config_r};
        end else if (hit_init) begin
            prdata_nxt = init_word;
        end else if (hit_loop) begin
            prdata_nxt = {24'h000000, loop_setup_r};
        end else if (hit_stat) begin
            prdata_nxt = stat_word;
        end
    end

    // Read data flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (setup_ph) begin
            prdata_r <= prdata_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign prdata = prdata_r;
    assign pready = 1'b1; // Zero-wait access
    assign pslverr = access_ph && !hit_any;
    assign ctl_out = ctl_r;
    assign clr_out = clr_r;
    assign phy_reset = phy_reset_pulse;

endmodule
`default_nettype wire

// >>> tb/mcpls_props.sv
`timescale 1ns/100ps
`default_nettype none
module mcpls_props
    import mcpls_pkg::*;
#(
    parameter int unsigned MAX_PACKETS = 100
) (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic media_converter_center, // Center mode
    input wire logic link_loss_strap, // Propagation strap
    input wire mcpls_link_s link_in, // Link status
    input wire mcpls_ctl_s ctl_out, // Transmit controls
    input wire logic phy_reset, // PHY reset out
    input wire mcpls_clr_s clr_out, // Clear pulses
    input wire logic loop_pkt_req, // Packet request
    input wire logic loop_pkt_ack // Packet sent
);
    // -----
    // Access decode
    // -----
    wire logic acc = psel && penable && pready;
    wire logic wr_init = acc && pwrite && paddr == {2'b00, IDX_INIT_LOW, 2'b00};
    wire logic wr_loop = acc && pwrite && paddr == {2'b00, IDX_LOOP_SETUP, 2'b00};
    wire logic wr_clear = wr_loop && pwdata[7:0] == LOOP_CLEAR_CODE;
    wire logic wr_count = wr_loop && pwdata[7:0] != 8'h00 && pwdata[7:0] <= MAX_PACKETS;
    wire logic unmapped = !(paddr inside {12'h100, 12'h10C, 12'h110, 12'h1F8});

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // -----
    // Properties
    // -----
    center_no_cut_a: assert property (media_converter_center |-> !ctl_out.copper_tx_disable)
        else $error("copper transmit cut in center mode");
    links_up_a: assert property ((link_in.fiber_up && link_in.center_copper_up) [*2]
        |=> !ctl_out.copper_tx_disable) else $error("copper cut with both links up");
    led_follow_a: assert property (ctl_out.copper_led_off == ctl_out.copper_tx_disable)
        else $error("copper leds differ from transmit cut");
    fiber_off_a: assert property (wr_init && pwdata[BIT_FIBER_TXD] |-> ##2 !ctl_out.fiber_tx_oe)
        else $error("fiber transmit still driven");
    fiber_on_a: assert property (wr_init && !pwdata[BIT_FIBER_TXD] |-> ##2 ctl_out.fiber_tx_oe)
        else $error("fiber transmit not restored");
    phy_pulse_a: assert property (wr_init && pwdata[BIT_PHY_RST] |-> ##[1:2] phy_reset)
        else $error("phy reset not raised");
    clear_pulse_a: assert property (wr_clear |=> clr_out.frame_ctr_clear
        && clr_out.loop_result_clear == media_converter_center) else $error("clear pulse wrong");
    clear_cause_a: assert property (clr_out.frame_ctr_clear |-> $past(wr_clear))
        else $error("clear pulse without clear write");
    loop_start_a: assert property (wr_count && media_converter_center |=> loop_pkt_req)
        else $error("loopback sequence not started");
    term_quiet_a: assert property (!media_converter_center |-> !loop_pkt_req
        && !clr_out.loop_result_clear) else $error("terminal mode acted on center code");
    unmapped_err_a: assert property (acc && unmapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");

    cover property (wr_count && media_converter_center);
    cover property (clr_out.loop_result_clear);
    cover property ($fell(ctl_out.fiber_tx_oe));
endmodule
bind mcpls_top mcpls_props #(.MAX_PACKETS(MAX_PACKETS)) mcpls_props_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .media_converter_center, .link_loss_strap,
    .link_in, .ctl_out, .phy_reset, .clr_out, .loop_pkt_req, .loop_pkt_ack);
`default_nettype wire

// >>> tb/mcpls_partner.sv
`timescale 1ns/100ps
`default_nettype none
module mcpls_partner
    import mcpls_pkg::*;
(
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, active low
    input wire mcpls_link_s link_cmd, // Link state asked by the bench
    input wire logic slow, // Send only every other cycle
    input wire logic loop_pkt_req, // Packet request from the block
    output mcpls_link_s link_in, // Link status seen by the block
    output logic loop_pkt_ack, // One packet sent
    output logic [7:0] pkt_count // Packets sent so far
);
    logic pace_r;
    // -----
    // Link partners and loopback packet sink
    // -----
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_in <= 2'b11;
            loop_pkt_ack <= 1'b0;
            pace_r <= 1'b0;
            pkt_count <= 8'h00;
        end else begin
            link_in <= link_cmd;
            pace_r <= !pace_r;
            loop_pkt_ack <= loop_pkt_req && (!slow || pace_r);
            if (loop_pkt_ack && loop_pkt_req) begin
                pkt_count <= pkt_count + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_mcpls_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_mcpls_top
    import mcpls_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic mc_center = 1'b0;
    logic strap = 1'b1;
    logic slow = 1'b0;
    mcpls_link_s link_cmd = 2'b11;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, phy_reset, loop_pkt_req, loop_pkt_ack;
    wire mcpls_link_s link_in;
    wire mcpls_ctl_s ctl_out;
    wire mcpls_clr_s clr_out;
    wire logic [7:0] pkt_count;
    int err_count = 0;
    int num_checks = 0;
    int fc_n = 0;
    int lr_n = 0;
    int n, b, bl;
    logic [31:0] q;
    logic e;
    logic [7:0] base;
    logic [7:0] codes [3] = '{8'h01, 8'h64, 8'h07};

    mcpls_top #(.MAX_PACKETS(100), .RST_CYCLES(4)) mcpls_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .media_converter_center(mc_center),
        .link_loss_strap(strap), .link_in, .ctl_out, .phy_reset, .clr_out, .loop_pkt_req, .loop_pkt_ack);
    mcpls_partner mcpls_partner_i (.pclk, .presetn, .link_cmd, .slow, .loop_pkt_req, .link_in,
        .loop_pkt_ack, .pkt_count);

    // -----
    // Clock and clear pulse counters
    // -----
    initial begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (clr_out.frame_ctr_clear === 1'b1) fc_n <= fc_n + 1;
        if (clr_out.loop_result_clear === 1'b1) lr_n <= lr_n + 1;
    end

    // -----
    // Bench tasks
    // -----
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic hang(input string what);
        err_count++;
        $display("mismatch at %0t: timeout %s", $time, what);
        give_verdict();
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        if (pready !== 1'b1) hang("apb");
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rst(input logic center, input logic lls);
        presetn <= 1'b0;
        mc_center <= center;
        strap <= lls;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // -----
    // Main sequence
    // -----
    initial begin
        rst(1'b0, 1'b1);
        apb(1'b0, IDX_LOOP_SETUP, 32'h0);
        chk(q, 32'h07, "setup reset");
        apb(1'b0, IDX_INIT_LOW, 32'h0);
        chk(q, 32'h04, "init reset terminal");
        apb(1'b0, 8'h01, 32'h0);
        chk({q[31:1], e}, 32'h1, "unmapped refused");
        for (int i = 0; i < 4; i++) begin
            link_cmd <= 2'(i);
            repeat (3) @(posedge pclk);
            chk({ctl_out.copper_tx_disable, ctl_out.copper_led_off}, (i == 3) ? 0 : 3, "copper cut");
        end
        apb(1'b1, IDX_INIT_LOW, 32'h6);
        repeat (2) @(posedge pclk);
        chk(ctl_out.fiber_tx_oe, 0, "fiber off");
        apb(1'b1, IDX_INIT_LOW, 32'h4);
        repeat (2) @(posedge pclk);
        chk(ctl_out.fiber_tx_oe, 1, "fiber on");
        base = pkt_count;
        apb(1'b1, IDX_LOOP_SETUP, 32'h33);
        apb(1'b1, IDX_INIT_LOW, 32'h5);
        n = 0;
        for (int i = 0; i < 12; i++) begin
            @(posedge pclk);
            if (phy_reset === 1'b1) n++;
        end
        chk(n, 4, "phy reset length");
        apb(1'b0, IDX_INIT_LOW, 32'h0);
        chk(q, 32'h04, "phy bit self clear");
        apb(1'b0, IDX_LOOP_SETUP, 32'h0);
        chk(q, 32'h33, "setup kept");
        chk(pkt_count - base, 0, "terminal sends none");
        b = fc_n;
        bl = lr_n;
        apb(1'b1, IDX_LOOP_SETUP, 32'h0);
        repeat (3) @(posedge pclk);
        chk(fc_n - b, 1, "terminal frame clear");
        chk(lr_n - bl, 0, "terminal result kept");
        $display("terminal mode test done");

        rst(1'b1, 1'b0);
        apb(1'b0, IDX_INIT_LOW, 32'h0);
        chk(q, 32'h01, "init reset center");
        chk(phy_reset, 1, "power up phy reset");
        apb(1'b1, IDX_MC_CONFIG, 32'h0);
        repeat (2) @(posedge pclk);
        chk(phy_reset, 0, "phy reset ends");
        apb(1'b1, IDX_INIT_LOW, 32'h4);
        link_cmd <= 2'b00;
        repeat (3) @(posedge pclk);
        chk(ctl_out.copper_tx_disable, 0, "center ignores propagation");
        link_cmd <= 2'b11;
        b = fc_n;
        bl = lr_n;
        apb(1'b1, IDX_LOOP_SETUP, 32'h0);
        repeat (3) @(posedge pclk);
        chk(fc_n - b + lr_n - bl, 2, "center clears both");
        // Only counts from 1 to 100 are ever written
        foreach (codes[i]) begin
            slow <= i[0];
            base = pkt_count;
            apb(1'b1, IDX_LOOP_SETUP, {24'h0, codes[i]});
            repeat (2) @(posedge pclk);
            n = 0;
            while (loop_pkt_req !== 1'b0 && n < 1000) begin
                @(posedge pclk);
                n++;
            end
            if (n == 1000) hang("loopback");
            repeat (2) @(posedge pclk);
            chk(pkt_count - base, codes[i], "packets sent");
        end
        $display("center mode test done");
        give_verdict();
    end
endmodule
`default_nettype wire
